// [logic/status_summary.v]
// Status summary byte of an instrument status reporting system with Avalon-MM slave
`include "status_summary_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module status_summary
#(
   parameter EVENT_WIDTH = 8
)
(
   // Clock and reset
   input  wire                   sys_clk,
   input  wire                   rst,
   // Avalon-MM slave
   input  wire [3:0]             avs_address,
   input  wire                   avs_read,
   input  wire                   avs_write,
   input  wire [31:0]            avs_writedata,
   output reg  [31:0]            avs_readdata,
   output reg                    avs_waitrequest,
   // Instrument conditions
   input  wire                   error_queue_not_empty,
   input  wire [EVENT_WIDTH-1:0] event_a_cond,
   input  wire [EVENT_WIDTH-1:0] event_b_cond,
   input  wire                   sequence_running,
   input  wire                   operator_seq_set,
   input  wire                   output_data_ready,
   // Instrument bus side
   input  wire                   serial_poll,
   input  wire                   status_byte_query_command,
   input  wire                   clear_status_command,
   input  wire                   bus_addressed_cmd,
   output reg  [7:0]             poll_byte,
   output reg                    poll_valid,
   output reg                    srq_out,
   output reg                    remote_mode,
   // Interrupt
   output reg                    irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   // Summary byte as last rebuilt from its sources
   reg [7:0]             summary_reg;
   // Event status latches and their condition history
   reg [EVENT_WIDTH-1:0] event_a_reg;
   reg [EVENT_WIDTH-1:0] event_b_reg;
   reg [EVENT_WIDTH-1:0] event_a_prev_reg;
   reg [EVENT_WIDTH-1:0] event_b_prev_reg;
   reg [EVENT_WIDTH-1:0] event_en_a_reg;
   reg [EVENT_WIDTH-1:0] event_en_b_reg;
   // Operator flag and interrupt bookkeeping
   reg                   seq_bit_reg;
   reg [3:0]             irq_status_reg;
   reg [3:0]             irq_mask_reg;
   reg                   error_prev_reg;
   reg                   srq_prev_reg;
   // Bus handshake state
   reg                   ans_pending_reg;

   reg [7:0]             summary_next;
   reg [3:0]             irq_set;
   reg [31:0]            read_mux;
   wire                  bus_req;
   wire                  bus_take;
   wire                  rd_event_a;
   wire                  rd_event_b;
   wire                  srq_level;
   // Rising-edge strobes of the event conditions
   wire [EVENT_WIDTH-1:0] onset_a;
   wire [EVENT_WIDTH-1:0] onset_b;
   // Decoded write strobes, one per writable register
   wire                  wr_control;
   wire                  wr_irq_status;
   wire                  wr_irq_mask;
   wire                  wr_en_a;
   wire                  wr_en_b;
   genvar                gi;

   // Zero-extend a narrow field into a bus word
   function [31:0] widen;
      input [7:0] val;
      begin
         widen = {24'h000000, val};
      end
   endfunction

   // Write strobe decode, shared by every writable register; one rule for all
   // strobes means no register can be written on a request still waiting
   function wr_hit;
      input       take;
      input       wr;
      input [3:0] addr;
      input [3:0] sel;
      begin
         wr_hit = take & wr & (addr == sel);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus request handling: one wait cycle, answer on the following edge
   assign bus_req  = avs_read | avs_write;
   assign bus_take = bus_req & ans_pending_reg;
   assign rd_event_a = bus_take & avs_read & (avs_address == `SSB_ADDR_EVENT_A);
   assign rd_event_b = bus_take & avs_read & (avs_address == `SSB_ADDR_EVENT_B);

   // Writes land only on the answer edge, the same edge the master samples it
   assign wr_control    = wr_hit(bus_take, avs_write, avs_address, `SSB_ADDR_CONTROL);
   assign wr_irq_status = wr_hit(bus_take, avs_write, avs_address, `SSB_ADDR_IRQ_STATUS);
   assign wr_irq_mask   = wr_hit(bus_take, avs_write, avs_address, `SSB_ADDR_IRQ_MASK);
   assign wr_en_a       = wr_hit(bus_take, avs_write, avs_address, `SSB_ADDR_EVENT_EN_A);
   assign wr_en_b       = wr_hit(bus_take, avs_write, avs_address, `SSB_ADDR_EVENT_EN_B);

   // Per-bit onset detectors; comparing against last cycle's level means a
   // condition held high across a clear does not latch a second time
   generate
      for (gi = 0; gi < EVENT_WIDTH; gi = gi + 1)
      begin : g_onset
         assign onset_a[gi] = event_a_cond[gi] & ~event_a_prev_reg[gi];
         assign onset_b[gi] = event_b_cond[gi] & ~event_b_prev_reg[gi];
      end
   endgenerate

   // srq_out is registered, so the summary's service request bit trails
   // the sources by two cycles
   // Service request raised while any enabled event bit or error is pending
   assign srq_level = (|(event_a_reg & event_en_a_reg)) |
                      (|(event_b_reg & event_en_b_reg)) | error_queue_not_empty;

   ////////////////////////////////////////////////////////////////////////////
   // Summary byte composition, rebuilt from sources each cycle
   // Bits 0 and 1 are unused and read zero
   always @*
   begin
      summary_next = 8'h00;
      summary_next[`SSB_BIT_ERROR]     = error_queue_not_empty;
      summary_next[`SSB_BIT_EVENT_A]   = |(event_a_reg & event_en_a_reg);
      summary_next[`SSB_BIT_EVENT_B]   = |(event_b_reg & event_en_b_reg);
      summary_next[`SSB_BIT_SRQ]       = srq_out;
      summary_next[`SSB_BIT_OUT_READY] = output_data_ready;
      summary_next[`SSB_BIT_SEQUENCE]  = seq_bit_reg;
   end

   // Summary register: only event register reads feed back into it, through the clear-on-read of the event bits
   // Polls and summary reads only observe summary_reg, so they cannot disturb it
   always @(posedge sys_clk)
   begin
      if (rst)
         summary_reg <= `SSB_RESET_BYTE;
      else
         summary_reg <= summary_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event status registers: latch on rising condition, clear on read or clear-status
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         event_a_reg      <= {EVENT_WIDTH{1'b0}};
         event_b_reg      <= {EVENT_WIDTH{1'b0}};
         event_a_prev_reg <= {EVENT_WIDTH{1'b0}};
         event_b_prev_reg <= {EVENT_WIDTH{1'b0}};
      end
      else
      begin
         event_a_prev_reg <= event_a_cond;
         event_b_prev_reg <= event_b_cond;
         // New onsets win over a clear in the same cycle
         // Clear-on-read uses the answer edge, where the read data is taken
         if (rd_event_a | clear_status_command)
            event_a_reg <= onset_a;
         else
            event_a_reg <= event_a_reg | onset_a;
         if (rd_event_b | clear_status_command)
            event_b_reg <= onset_b;
         else
            event_b_reg <= event_b_reg | onset_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencing bit: operator may only set it while a sequence executes
   // Operator set wins over a control write in the same cycle, so software
   // racing the front panel cannot drop the flag of a running sequence
   always @(posedge sys_clk)
   begin
      if (rst)
         seq_bit_reg <= 1'b0;
      else if (sequence_running & operator_seq_set)
         seq_bit_reg <= 1'b1;
      else if (wr_control)
         seq_bit_reg <= avs_writedata[`SSB_CTRL_SEQ_BIT];
      else if (clear_status_command)
         seq_bit_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Instrument bus answers and remote state
   // Limitation: remote is left only by a control write; there is no lockout,
   // the front panel stays live in either state
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         poll_byte   <= `SSB_RESET_BYTE;
         poll_valid  <= 1'b0;
         srq_out     <= 1'b0;
         remote_mode <= 1'b0;
      end
      else
      begin
         srq_out    <= srq_level;
         poll_valid <= serial_poll | status_byte_query_command;
         if (serial_poll | status_byte_query_command)
            poll_byte <= summary_reg;
         // Serial poll leaves the local/remote state alone
         if (status_byte_query_command | bus_addressed_cmd)
            remote_mode <= 1'b1;
         else if (wr_control &
                  ~avs_writedata[`SSB_CTRL_REMOTE_BIT])
            remote_mode <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt events: rising edges of error pending, service request, event bits
   // A condition already high at reset release counts as an onset once
   always @*
   begin
      irq_set = 4'h0;
      irq_set[`SSB_IRQ_ERROR]   = error_queue_not_empty & ~error_prev_reg;
      irq_set[`SSB_IRQ_EVENT_A] = |onset_a;
      irq_set[`SSB_IRQ_EVENT_B] = |onset_b;
      irq_set[`SSB_IRQ_SRQ]     = srq_level & ~srq_prev_reg;
   end

   // Sticky status, write-one-to-clear; a set in the clear cycle survives
   // irq is registered from the sticky bits, so it trails a set or a clear by
   // one cycle; mask reset to zero keeps irq low until software opts in
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         irq_status_reg <= `SSB_RESET_IRQ;
         irq_mask_reg   <= `SSB_RESET_IRQ;
         error_prev_reg <= 1'b0;
         srq_prev_reg   <= 1'b0;
         irq            <= 1'b0;
      end
      else
      begin
         error_prev_reg <= error_queue_not_empty;
         srq_prev_reg   <= srq_level;
         if (wr_irq_status)
            irq_status_reg <= (irq_status_reg & ~avs_writedata[3:0]) | irq_set;
         else
            irq_status_reg <= irq_status_reg | irq_set;
         if (wr_irq_mask)
            irq_mask_reg <= avs_writedata[3:0];
         irq <= |(irq_status_reg & irq_mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event enable registers
   // Enables reset to all ones so every event reaches the summary by default
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         event_en_a_reg <= `SSB_RESET_EN;
         event_en_b_reg <= `SSB_RESET_EN;
      end
      else
      begin
         if (wr_en_a)
            event_en_a_reg <= avs_writedata[EVENT_WIDTH-1:0];
         if (wr_en_b)
            event_en_b_reg <= avs_writedata[EVENT_WIDTH-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data multiplexer; unmapped addresses read zero
   // The mux has no side effect: event clears are decoded from the answer edge
   always @*
   begin
      case (avs_address)
         `SSB_ADDR_SUMMARY:    read_mux = widen(summary_reg);
         `SSB_ADDR_EVENT_A:    read_mux = widen(event_a_reg);
         `SSB_ADDR_EVENT_B:    read_mux = widen(event_b_reg);
         `SSB_ADDR_CONTROL:    read_mux = widen({6'h00, remote_mode, seq_bit_reg});
         `SSB_ADDR_IRQ_STATUS: read_mux = widen({4'h0, irq_status_reg});
         `SSB_ADDR_IRQ_MASK:   read_mux = widen({4'h0, irq_mask_reg});
         `SSB_ADDR_EVENT_EN_A: read_mux = widen(event_en_a_reg);
         `SSB_ADDR_EVENT_EN_B: read_mux = widen(event_en_b_reg);
         default:              read_mux = 32'h00000000;
      endcase
   end

   // Waitrequest stays high by default; drops for one cycle to answer
   // A fixed wait cycle keeps the read mux off the answer path at the cost of
   // two cycles per access; ans_pending_reg stops a held request being taken twice
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         ans_pending_reg <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end
      else
      begin
         if (bus_req & ~ans_pending_reg)
         begin
            ans_pending_reg <= 1'b1;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= read_mux;
         end
         else
         begin
            ans_pending_reg <= 1'b0;
            avs_waitrequest <= 1'b1;
         end
      end
   end

endmodule // status_summary

// [logic/status_summary_defines.vh]
// Register offsets, bit positions, reset values and timing counts of the status summary block
`ifndef STATUS_SUMMARY_DEFINES_VH
`define STATUS_SUMMARY_DEFINES_VH

// Register word addresses (consecutive, one per register)
`define SSB_ADDR_SUMMARY     4'h0
`define SSB_ADDR_EVENT_A     4'h1
`define SSB_ADDR_EVENT_B     4'h2
`define SSB_ADDR_CONTROL     4'h3
`define SSB_ADDR_IRQ_STATUS  4'h4
`define SSB_ADDR_IRQ_MASK    4'h5
`define SSB_ADDR_EVENT_EN_A  4'h6
`define SSB_ADDR_EVENT_EN_B  4'h7

// Summary byte bit positions
`define SSB_BIT_EVENT_B      2
`define SSB_BIT_ERROR        3
`define SSB_BIT_OUT_READY    4
`define SSB_BIT_EVENT_A      5
`define SSB_BIT_SRQ          6
`define SSB_BIT_SEQUENCE     7

// Control register fields
`define SSB_CTRL_SEQ_BIT     0
`define SSB_CTRL_REMOTE_BIT  1

// Interrupt status bit positions
`define SSB_IRQ_ERROR        0
`define SSB_IRQ_EVENT_A      1
`define SSB_IRQ_EVENT_B      2
`define SSB_IRQ_SRQ          3

// Reset values
`define SSB_RESET_BYTE       8'h00
`define SSB_RESET_EN         8'hFF
`define SSB_RESET_IRQ        4'h0

// Bus answer latency in cycles after a request is seen
`define SSB_BUS_WAIT_CYCLES  1

`endif

// [tb/bus_ctl_model.sv]
// Bus controller model that polls, queries and commands the block
module bus_ctl_model (
   // Clock
   input  wire logic       sys_clk,
   // Answer from the block
   input  wire logic [7:0] poll_byte,
   input  wire logic       poll_valid,
   // Command pulses
   output wire logic       serial_poll,
   output wire logic       status_byte_query_command,
   output wire logic       clear_status_command,
   output wire logic       bus_addressed_cmd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cmd_reg = 4'h0;
   assign {serial_poll, status_byte_query_command, clear_status_command, bus_addressed_cmd} = cmd_reg;
   ////////////////////////////////////////////////////////////////////////////////
   // One-cycle pulse, then a bounded wait for the byte; clear and remote give none
   task automatic send(input logic [3:0] cmd, output logic [7:0] b, output bit ok);
      int i;
      ok = 1'b0;
      b = 8'h00;
      @(posedge sys_clk);
      cmd_reg <= cmd;
      @(posedge sys_clk);
      cmd_reg <= 4'h0;
      for (i = 0; i < 4 && !ok; i++)
      begin
         @(negedge sys_clk);
         ok = (poll_valid === 1'b1);
         b = poll_byte;
      end
   endtask
endmodule // bus_ctl_model

// [tb/status_summary_sva.sv]
// Port-level assertions for the status summary byte block
module status_summary_sva (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       rst,
   // Requests and sources
   input wire logic       avs_read,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   input wire logic       error_queue_not_empty,
   input wire logic       output_data_ready,
   input wire logic       serial_poll,
   input wire logic       status_byte_query_command,
   input wire logic       bus_addressed_cmd,
   // Watched outputs
   input wire logic [7:0] poll_byte,
   input wire logic       poll_valid,
   input wire logic       srq_out,
   input wire logic       remote_mode,
   input wire logic       irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Polled byte follows sources two cycles back, once reset is long gone
   err_bit_a: assert property (poll_valid && !$past(rst, 2)
      |-> poll_byte[3] == $past(error_queue_not_empty, 2)) else $error("error bit wrong");
   out_bit_a: assert property (poll_valid && !$past(rst, 2)
      |-> poll_byte[4] == $past(output_data_ready, 2)) else $error("ready bit wrong");
   srq_bit_a: assert property (poll_valid && !$past(rst, 2)
      |-> poll_byte[6] == $past(srq_out, 2)) else $error("srq bit wrong");
   // Both read methods answer on the next cycle
   poll_ans_a: assert property (serial_poll || status_byte_query_command
      |=> poll_valid) else $error("no poll answer");
   // A plain poll must leave local control alone
   poll_local_a: assert property (serial_poll && !status_byte_query_command
      && !bus_addressed_cmd && !avs_write |=> $stable(remote_mode)) else $error("poll went remote");
   query_remote_a: assert property ((status_byte_query_command || bus_addressed_cmd)
      && !avs_write |=> remote_mode) else $error("query stayed local");
   reset_zero_a: assert property (@(posedge sys_clk) disable iff (1'b0) rst
      |=> poll_byte == 8'h00 && !poll_valid && !srq_out && !irq) else $error("reset not clean");
   bus_ans_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus answer late");
endmodule // status_summary_sva

bind status_summary status_summary_sva u_sva (.*);

// [tb/tb_status_summary.sv]
// Self-checking bench for the status summary byte block
`include "status_summary_defines.vh"
module tb_status_summary;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [7:0]  event_a_cond = 8'h00;
   logic [7:0]  event_b_cond = 8'h00;
   logic        error_queue_not_empty = 1'b0;
   logic        sequence_running = 1'b0;
   logic        operator_seq_set = 1'b0;
   logic        output_data_ready = 1'b0;
   wire  [31:0] avs_readdata;
   wire  [7:0]  poll_byte;
   wire         avs_waitrequest, poll_valid, srq_out, remote_mode, irq;
   wire         serial_poll, status_byte_query_command, clear_status_command, bus_addressed_cmd;
   logic [31:0] q;
   int          fails = 0;
   int          n_compared = 0;
   status_summary u_dut (.*);
   bus_ctl_model  u_ctl (.*);
   always #50 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Held request, answer taken only on the edge that sees waitrequest low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      for (i = 0; i < 8; i++)
      begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      if (i == 8)
      begin
         fails++;
         end_of_test();
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // Command 8 poll, 4 query, 2 clear, 1 other
   task automatic poll(input logic [3:0] c, input logic [7:0] exp);
      logic [7:0] b;
      bit         ok;
      u_ctl.send(c, b, ok);
      if (c[3:2] != 2'b00 && !ok)
      begin
         fails++;
         end_of_test();
      end
      if (c[3:2] != 2'b00)
         chk({24'h0, b}, {24'h0, exp});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_error;
      error_queue_not_empty <= 1'b1;
      tick(4);
      poll(4'h8, 8'h48);
      chk(remote_mode, 1'b0);
      poll(4'h8, 8'h48);
      bus(1'b0, `SSB_ADDR_SUMMARY, 0); chk(q, 32'h48);
      poll(4'h4, 8'h48);
      chk(remote_mode, 1'b1);
      chk(irq, 1'b0);
      bus(1'b1, `SSB_ADDR_IRQ_MASK, 32'h1); tick(2); chk(irq, 1'b1);
      bus(1'b1, `SSB_ADDR_IRQ_STATUS, 32'h1); tick(2); chk(irq, 1'b0);
      bus(1'b0, `SSB_ADDR_IRQ_STATUS, 0); chk(q, 32'h8);
      bus(1'b1, `SSB_ADDR_CONTROL, 0); tick(1); chk(remote_mode, 1'b0);
      poll(4'h1, 8'h00); chk(remote_mode, 1'b1);
      bus(1'b1, `SSB_ADDR_CONTROL, 0); bus(1'b0, 4'hF, 0); chk(q, 32'h0);
      error_queue_not_empty <= 1'b0;
      tick(4);
      poll(4'h8, 8'h00);
      $display("t_error done");
   endtask
   task automatic t_events;
      event_a_cond <= 8'h01; tick(1); event_a_cond <= 8'h00; tick(4);
      poll(4'h8, 8'h60);
      bus(1'b0, `SSB_ADDR_EVENT_A, 0); chk(q, 32'h1);
      tick(3); poll(4'h8, 8'h00);
      event_b_cond <= 8'h80; tick(1); event_b_cond <= 8'h00; tick(4);
      poll(4'h8, 8'h44);
      poll(4'h2, 8'h00); tick(3); poll(4'h8, 8'h00);
      $display("t_events done");
   endtask
   task automatic t_seq;
      operator_seq_set <= 1'b1; tick(1); operator_seq_set <= 1'b0; tick(3);
      poll(4'h8, 8'h00);
      output_data_ready <= 1'b1; sequence_running <= 1'b1; operator_seq_set <= 1'b1;
      tick(1); operator_seq_set <= 1'b0; tick(4);
      poll(4'h8, 8'h90);
      poll(4'h2, 8'h00); tick(3); poll(4'h8, 8'h10);
      rst <= 1'b1; tick(3); rst <= 1'b0; tick(1);
      chk(poll_byte, 8'h00); chk(srq_out, 1'b0);
      $display("t_seq done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      tick(3);
      rst <= 1'b0;
      bus(1'b0, `SSB_ADDR_SUMMARY, 0); chk(q, 32'h0);
      t_error();
      t_events();
      t_seq();
      end_of_test();
   end
endmodule // tb_status_summary
